// file: hw/pcl_loader.sv
// module: fast parallel configuration loader with apb registers
// Function
// - in 32-bit mode one word is taken every 1, 4 or 8 clocks per security and decompression.
// - a low reconfig_request_n restarts configuration from any state but the power-on wait, user mode included.
// - in user mode status and complete lines both sit high.
// - after power-up the status line stays low for the whole power-on delay.
// - the complete line stays low after power-up, before and during loading.
// - config_clock is ignored once user mode is entered; the host never floats it.
// - 16-bit mode uses data lines 15..0, 8-bit mode 7..0; all lines turn user after loading.
// - the complete line rises only after the full image of expect words arrived, on the last clock of the last word.
// - two falling config_clock edges after completion start initialization and user mode.
// - once init-done is enabled, that output is low until initialization ends.
// - the chain-enable output may be left open or used as user I/O when unchained; here it is never user I/O, only driven low after loading, high otherwise.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module pcl_loader
    import pcl_pkg::*;
#(
    parameter int POR_COUNT = POR_CYCLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    input wire logic config_clock_in,
    input wire logic reconfig_request_n_in,
    input wire logic [31:0] data_in,
    output logic load_status_line_out,
    output logic load_complete_line_out,
    output logic init_done_out,
    output logic chain_enable_n_out,
    output logic user_mode_out,
    output logic [31:0] user_data_out
);
    logic [33:0] pins_s;
    logic config_clock_s;
    logic nreq_s;
    logic [31:0] data_s;

    // pins cross via two flops before any logic reads them
    pcl_sync #(.W(34)) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .async_in({config_clock_in, reconfig_request_n_in, data_in}),
        .sync_out(pins_s)
    );
    assign config_clock_s = pins_s[33];
    assign nreq_s = pins_s[32];
    assign data_s = pins_s[31:0];

    pcl_state_t state_q, state_d;
    logic [31:0] por_cnt_q, por_cnt_d;
    logic config_clock_q, config_clock_d;
    logic [3:0] phase_q, phase_d;
    logic [1:0] fall_q, fall_d;
    logic [31:0] words_q, words_d;
    logic [31:0] last_q, last_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] expect_q, expect_d;
    logic [IRQ_NBITS-1:0] istat_q, istat_d;
    logic [IRQ_NBITS-1:0] imask_q, imask_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;
    logic status_q, status_d;
    logic done_q, done_d;
    logic init_q, init_d;
    logic ceo_q, ceo_d;
    logic user_q, user_d;
    logic [31:0] udata_q, udata_d;

    logic rise;
    logic fall;
    logic [3:0] ratio;
    logic [1:0] width;
    logic [31:0] word_masked;
    logic [IRQ_NBITS-1:0] ev;
    logic wr_acc;
    logic rd_acc;

    assign rise = config_clock_s & ~config_clock_q;
    assign fall = ~config_clock_s & config_clock_q;
    assign width = ctrl_q[CTRL_WIDTH_LSB +: 2];

    always_comb begin
        // ratio applies to the 32-bit scheme; narrower widths take one word per clock
        if (width != WIDTH_32) begin
            ratio = RATIO_PLAIN;
        end else if (ctrl_q[CTRL_DECOMP_BIT]) begin
            ratio = RATIO_DECOMP;
        end else if (ctrl_q[CTRL_SECURE_BIT]) begin
            ratio = RATIO_SECURE;
        end else begin
            ratio = RATIO_PLAIN;
        end
    end

    always_comb begin
        unique case (width)
            WIDTH_8: word_masked = {24'h000000, data_s[7:0]};
            WIDTH_16: word_masked = {16'h0000, data_s[15:0]};
            default: word_masked = data_s;
        endcase
    end

    // loader state machine
    always_comb begin
        state_d = state_q;
        por_cnt_d = por_cnt_q;
        config_clock_d = config_clock_s;
        phase_d = phase_q;
        fall_d = fall_q;
        words_d = words_q;
        last_d = last_q;
        status_d = status_q;
        done_d = done_q;
        init_d = init_q;
        ceo_d = ceo_q;
        user_d = user_q;
        udata_d = udata_q;
        ev = '0;
        unique case (state_q)
            ST_POR: begin
                status_d = 1'b0;
                done_d = 1'b0;
                if (por_cnt_q >= 32'(POR_COUNT - 1)) begin
                    state_d = ST_RESET;
                end else begin
                    por_cnt_d = por_cnt_q + 32'h0000_0001;
                end
            end
            ST_RESET: begin
                status_d = 1'b0;
                done_d = 1'b0;
                if (nreq_s) begin
                    state_d = ST_LOAD;
                    status_d = 1'b1;
                    phase_d = '0;
                    words_d = '0;
                end
            end
            ST_LOAD: begin
                if (rise) begin
                    if (phase_q == 4'h0) begin
                        last_d = word_masked;
                        words_d = words_q + 32'h0000_0001;
                    end
                    // extra clocks of a word go to decrypt/decompress
                    if (phase_q + 4'h1 >= ratio) begin
                        phase_d = '0;
                        // words_d already counts this group's word
                        if (words_d >= expect_q && phase_q + 4'h1 == ratio) begin
                            state_d = ST_INIT;
                            done_d = 1'b1;
                            ceo_d = 1'b0;
                            fall_d = '0;
                            ev[IRQ_DONE] = 1'b1;
                        end
                    end else begin
                        phase_d = phase_q + 4'h1;
                    end
                end
            end
            ST_INIT: begin
                if (fall) begin
                    if (fall_q == 2'(INIT_EDGES - 1)) begin
                        state_d = ST_USER;
                        user_d = 1'b1;
                        init_d = 1'b1;
                        ev[IRQ_USER] = 1'b1;
                    end else begin
                        fall_d = fall_q + 2'h1;
                    end
                end
            end
            ST_USER: begin
                // config_clock no longer looked at
                status_d = 1'b1;
                done_d = 1'b1;
                udata_d = data_s;
            end
            default: state_d = ST_RESET;
        endcase
        // low request restarts from anywhere but the power-on wait
        if (!nreq_s && state_q != ST_POR) begin
            state_d = ST_RESET;
            status_d = 1'b0;
            done_d = 1'b0;
            user_d = 1'b0;
            ceo_d = 1'b1;
            if (state_q != ST_RESET) begin
                ev[IRQ_RECONF] = 1'b1;
            end
        end
        // init-done low until user mode once enabled
        if (!user_d) begin
            init_d = ~ctrl_q[CTRL_INITEN_BIT];
        end
        if (!user_d) begin
            udata_d = '0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= ST_POR;
            por_cnt_q <= '0;
            config_clock_q <= 1'b0;
            phase_q <= '0;
            fall_q <= '0;
            words_q <= '0;
            last_q <= '0;
            status_q <= 1'b0;
            done_q <= 1'b0;
            init_q <= 1'b1;
            ceo_q <= 1'b1; // unchained use leaves it open
            user_q <= 1'b0;
            udata_q <= '0;
        end else begin
            state_q <= state_d;
            por_cnt_q <= por_cnt_d;
            config_clock_q <= config_clock_d;
            phase_q <= phase_d;
            fall_q <= fall_d;
            words_q <= words_d;
            last_q <= last_d;
            status_q <= status_d;
            done_q <= done_d;
            init_q <= init_d;
            ceo_q <= ceo_d;
            user_q <= user_d;
            udata_q <= udata_d;
        end
    end

    // apb slave, zero wait states
    assign wr_acc = psel_in & penable_in & pwrite_in;
    assign rd_acc = psel_in & ~penable_in & ~pwrite_in;

    always_comb begin
        ctrl_d = ctrl_q;
        expect_d = expect_q;
        imask_d = imask_q;
        // set wins over write-one clear
        istat_d = istat_q;
        prdata_d = prdata_q;
        pready_d = psel_in & ~penable_in;
        pslverr_d = 1'b0;
        if (wr_acc) begin
            unique case (paddr_in)
                REG_CTRL: ctrl_d = pwdata_in;
                REG_EXPECT: expect_d = pwdata_in;
                REG_IRQ_MASK: imask_d = pwdata_in[IRQ_NBITS-1:0];
                REG_IRQ_STAT: istat_d = istat_q & ~pwdata_in[IRQ_NBITS-1:0];
                default: ;
            endcase
        end
        istat_d = istat_d | ev;
        if (rd_acc) begin
            unique case (paddr_in)
                REG_CTRL: prdata_d = ctrl_q;
                REG_STATUS: prdata_d = {24'h000000, user_q, init_q, done_q, status_q,
                                        1'b0, 3'(state_q)};
                REG_IRQ_STAT: prdata_d = {29'h0, istat_q};
                REG_IRQ_MASK: prdata_d = {29'h0, imask_q};
                REG_WORDS: prdata_d = words_q;
                REG_EXPECT: prdata_d = expect_q;
                REG_LAST: prdata_d = last_q;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        if (psel_in & ~penable_in) begin
            unique case (paddr_in)
                REG_CTRL, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK,
                REG_WORDS, REG_EXPECT, REG_LAST: pslverr_d = 1'b0;
                default: pslverr_d = 1'b1;
            endcase
        end
        irq_d = |(istat_d & imask_d);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q <= CTRL_RESET;
            expect_q <= EXPECT_RESET;
            istat_q <= '0;
            imask_q <= '0;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            expect_q <= expect_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign irq_out = irq_q;
    assign load_status_line_out = status_q;
    assign load_complete_line_out = done_q;
    assign init_done_out = init_q;
    assign chain_enable_n_out = ceo_q;
    assign user_mode_out = user_q;
    assign user_data_out = udata_q;
endmodule : pcl_loader

// file: common/pcl_pkg.sv
// package: constants for the parallel configuration loader
package pcl_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int POR_DELAY_US = 100;
    localparam int POR_CYCLES = (POR_DELAY_US * (CLK_HZ / 1000000));
    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_WORDS = 8'h10;
    localparam logic [7:0] REG_EXPECT = 8'h14;
    localparam logic [7:0] REG_LAST = 8'h18;
    // ctrl fields
    localparam int CTRL_WIDTH_LSB = 0;
    localparam int CTRL_DECOMP_BIT = 2;
    localparam int CTRL_SECURE_BIT = 3;
    localparam int CTRL_INITEN_BIT = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    localparam logic [31:0] EXPECT_RESET = 32'h0000_0010;
    // width codes
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    // clock-per-word ratios
    localparam logic [3:0] RATIO_PLAIN = 4'h1;
    localparam logic [3:0] RATIO_SECURE = 4'h4;
    localparam logic [3:0] RATIO_DECOMP = 4'h8;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_USER = 1;
    localparam int IRQ_RECONF = 2;
    localparam int IRQ_NBITS = 3;
    localparam int INIT_EDGES = 2;
    typedef enum logic [2:0] {
        ST_POR, ST_RESET, ST_LOAD, ST_INIT, ST_USER
    } pcl_state_t;
endpackage : pcl_pkg

// file: hw/pcl_sync.sv
// module: two-flop synchroniser for link pins
`timescale 1ns/1ns
module pcl_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : pcl_sync

// file: sim/pcl_host.sv
// partner: external host clocking configuration words into the loader
`timescale 1ns/1ns
module pcl_host (
    input wire logic status_in,
    output logic cclk_out,
    output logic nreq_n_out,
    output logic [31:0] data_out
);
    initial begin
        cclk_out = 1'b0; // parked low, never floated
        nreq_n_out = 1'b1;
        data_out = 32'h0F0F_0F0F;
    end
    task automatic pulse(input int r);
        #7;
        repeat (r) begin
            #200 cclk_out = 1'b1; // 400 ns period, ratio times word rate
            #200 cclk_out = 1'b0;
        end
    endtask : pulse
    task automatic restart();
        nreq_n_out = 1'b0;
        #1000 nreq_n_out = 1'b1;
    endtask : restart
    task automatic send(input int n, input int r, input logic [31:0] w);
        wait (status_in === 1'b1);
        for (int i = 0; i < n; i++) begin
            data_out = w + 32'(i); // every word sent
            pulse(r); // held r clocks, r-1 after latch
        end
        data_out = ~data_out; // released lines show no stale word
    endtask : send
endmodule : pcl_host

// file: sim/pcl_loader_chk.sv
// checker: port-level assertions for the configuration loader
`timescale 1ns/1ns
module pcl_loader_chk #(
    parameter int POR_COUNT = 10
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic reconfig_request_n_in,
    input wire logic pready_out,
    input wire logic load_status_line_out,
    input wire logic load_complete_line_out,
    input wire logic init_done_out,
    input wire logic user_mode_out,
    input wire logic [31:0] user_data_out
);
    logic [15:0] por_q;
    logic [15:0] por_d;
    always_comb begin
        por_d = (por_q < 16'(POR_COUNT)) ? por_q + 16'h1 : por_q;
    end
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            por_q <= 16'h0;
        end else begin
            por_q <= por_d;
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    AST_POR_STATUS: assert property (por_q < 16'(POR_COUNT) |-> !load_status_line_out)
        else $error("status line released inside power-on delay");
    AST_POR_DONE: assert property (por_q < 16'(POR_COUNT) |-> !load_complete_line_out)
        else $error("complete line high inside power-on delay");
    AST_USER_LINES: assert property (user_mode_out |-> load_status_line_out && load_complete_line_out)
        else $error("user mode without status and complete high");
    AST_RESTART: assert property ((!reconfig_request_n_in && por_q == 16'(POR_COUNT))[*6]
        |-> !load_complete_line_out && !user_mode_out)
        else $error("restart request did not clear configuration");
    AST_INIT_EDGES: assert property ($rose(user_mode_out) |-> $past(load_complete_line_out, 6))
        else $error("user mode entered too soon after completion");
    AST_INIT_DONE: assert property (user_mode_out |-> init_done_out)
        else $error("init done low in user mode");
    AST_USER_DATA: assert property (!user_mode_out |-> user_data_out == 32'h0000_0000)
        else $error("data lines passed to user before user mode");
    AST_CLOCK_IGNORED: assert property (user_mode_out && reconfig_request_n_in |=> user_mode_out)
        else $error("user mode left without restart");
    AST_APB_READY: assert property (psel_in && !penable_in |=> pready_out)
        else $error("apb access phase without ready");
endmodule : pcl_loader_chk
bind pcl_loader pcl_loader_chk #(.POR_COUNT(POR_COUNT)) u_chk (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .reconfig_request_n_in(reconfig_request_n_in),
    .pready_out(pready_out),
    .load_status_line_out(load_status_line_out),
    .load_complete_line_out(load_complete_line_out),
    .init_done_out(init_done_out),
    .user_mode_out(user_mode_out),
    .user_data_out(user_data_out)
);

// file: sim/tb_top.sv
// testbench: apb and link level checks of the configuration loader
`timescale 1ns/1ns
module tb_top
    import pcl_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, irq, cck, nreq, status, cmpl, initd, chain, user, re;
    logic [31:0] prdata, data, udata, rv;
    int err_count = 0;
    int cmp_count = 0;
    logic [40:0] regs [6] = '{{1'b0, REG_CTRL, CTRL_RESET}, {1'b0, REG_IRQ_MASK, 32'h0},
        {1'b0, REG_WORDS, 32'h0}, {1'b0, REG_EXPECT, EXPECT_RESET}, {1'b0, REG_LAST, 32'h0},
        {1'b1, 8'h1C, 32'h0}};
    logic [31:0] ctl [6] = '{32'h02, 32'h1A, 32'h16, 32'h1E, 32'h10, 32'h11};
    int rat [6] = '{1, 4, 8, 8, 1, 1};
    logic [31:0] msk [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'hFF, 32'hFFFF};
    always #25 clk = ~clk;
    pcl_loader #(.POR_COUNT(10)) uut (.clk_in(clk), .rstn_in(rstn), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
        .config_clock_in(cck), .reconfig_request_n_in(nreq), .data_in(data),
        .load_status_line_out(status), .load_complete_line_out(cmpl),
        .init_done_out(initd), .chain_enable_n_out(chain), .user_mode_out(user),
        .user_data_out(udata));
    pcl_host host (.status_in(status), .cclk_out(cck), .nreq_n_out(nreq), .data_out(data));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // look mid-cycle, where the registered answer has settled
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, 32'(pready));
        rv = prdata;
        re = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("rdata", e, rv);
    endtask : rd
    task automatic results();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        chk("status", 32'h0, 32'(status));
        for (int i = 0; i < 6; i++) begin
            rd(regs[i][39:32], regs[i][31:0]);
            chk("pslverr", 32'(regs[i][40]), 32'(re));
        end
        apb(1'b1, REG_IRQ_MASK, 32'h1);
        apb(1'b1, REG_EXPECT, 32'h3);
        for (int m = 0; m < 6; m++) begin
            apb(1'b1, REG_CTRL, ctl[m]);
            apb(1'b1, REG_IRQ_STAT, 32'h7);
            if (m > 0) begin
                host.restart();
            end
            host.send(2, rat[m], 32'h8BAD_F00D + 32'(m));
            chk("complete", 32'h0, 32'(cmpl));
            chk("init", 32'(!ctl[m][4]), 32'(initd));
            host.send(1, rat[m], 32'h8BAD_F00F + 32'(m));
            chk("complete", 32'h1, 32'(cmpl));
            rd(REG_WORDS, 32'h3);
            rd(REG_LAST, (32'h8BAD_F00F + 32'(m)) & msk[m]);
            repeat (2) @(posedge clk);
            chk("irq", 32'h1, 32'(irq));
            apb(1'b1, REG_IRQ_STAT, 32'h1);
            repeat (2) @(posedge clk);
            chk("irq", 32'h0, 32'(irq));
            chk("chain", 32'h0, 32'(chain));
            // only the last word's own fall has come so far
            chk("user", 32'h0, 32'(user));
            host.pulse(2);
            repeat (4) @(posedge clk);
            chk("user", 32'h1, 32'(user));
            chk("init", 32'h1, 32'(initd));
        end
        // link clocks in user mode must not load words
        host.send(3, 1, 32'h5A5A_0FF0);
        repeat (5) @(posedge clk);
        chk("udata", 32'hA5A5_F00D, udata);
        rd(REG_WORDS, 32'h3);
        chk("user", 32'h1, 32'(user));
        host.restart();
        repeat (4) @(posedge clk);
        chk("user", 32'h0, 32'(user));
        chk("complete", 32'h0, 32'(cmpl));
        chk("irq", 32'h0, 32'(irq));
        rd(REG_IRQ_STAT, 32'h6);
        results();
    end
    initial begin
        #1000000;
        err_count++;
        results();
    end
endmodule : tb_top
